// file: hw/wdt_clk_div.sv
// Prescaler that makes the watchdog input clock as a one-cycle enable
`include "wdt_map.svh"

module wdt_clk_div (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire wdt_pkg::wdt_div_t sel_i,
  output logic tick_o
);

  logic [9:0] div_cnt;
  wire logic [9:0] div_lim;
  wire logic at_end;

  // Ratio decode
  assign div_lim = (sel_i == wdt_pkg::WDT_DIV_1) ? `WDT_DIV_SEL0 :
                   (sel_i == wdt_pkg::WDT_DIV_8) ? `WDT_DIV_SEL1 :
                   (sel_i == wdt_pkg::WDT_DIV_64) ? `WDT_DIV_SEL2 :
                   `WDT_DIV_SEL3;
  assign at_end = (div_cnt >= div_lim - 10'h001);
  // Stopped divider restarts from zero so the first period is whole
  assign tick_o = run_i & at_end;

  // Divide counter; >= keeps it sane if the ratio shrinks mid-count
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i || !run_i || at_end)
      div_cnt <= 10'h000;
    else
      div_cnt <= div_cnt + 10'h001;
  end

endmodule : wdt_clk_div

// file: hw/wdt_top.sv
// Watchdog reset timer with APB register access and a level interrupt
//
// Behaviour
// - an 8-bit counter steps up once per selected input clock while running.
// - run starts only on run=1 with its inhibit 0 while write-enable is 1.
// - a tick at count FF overflows and raises the internal reset request.
// - the internal reset stays high exactly 256 oscillator clock cycles.
// - the counter is writable except during the internal reset pulse; counting continues from it.
// - preloading the counter gives overflow after 1 to 256 input clocks.
`include "wdt_map.svh"

module wdt_top (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  output logic wdt_reset_o
);

  // Control and counter state
  logic ctrl_write_enable_bit;
  logic wdog_run_bit;
  logic [7:0] wdog_counter;
  wdt_pkg::wdt_div_t clk_sel;
  wdt_pkg::wdt_evt_t status;
  wdt_pkg::wdt_evt_t mask;
  logic [8:0] rst_left;
  logic tick;

  // Bus phase decode
  wire logic access_cyc;
  wire logic done_cyc;
  wire logic wr_done;
  wire logic rd_done;
  assign access_cyc = psel_i & penable_i & ~pready_o;
  assign done_cyc = psel_i & penable_i & pready_o;
  assign wr_done = done_cyc & pwrite_i;
  assign rd_done = done_cyc & ~pwrite_i;

  // Address decode
  wire logic hit_ctrl;
  wire logic hit_count;
  wire logic hit_clksel;
  wire logic hit_status;
  wire logic hit_mask;
  wire logic hit_any;
  assign hit_ctrl = (paddr_i == `WDT_OFF_CTRL);
  assign hit_count = (paddr_i == `WDT_OFF_COUNT);
  assign hit_clksel = (paddr_i == `WDT_OFF_CLKSEL);
  assign hit_status = (paddr_i == `WDT_OFF_STATUS);
  assign hit_mask = (paddr_i == `WDT_OFF_MASK);
  assign hit_any = hit_ctrl | hit_count | hit_clksel | hit_status | hit_mask;

  // Control write fields
  wdt_pkg::wdt_ctrl_t wr_ctrl;
  assign wr_ctrl = wdt_pkg::wdt_ctrl_t'(pwdata_i[3:0]);

  // Reset pulse in progress; writes to control, counter and clock select are held off
  wire logic rst_busy;
  wire logic rst_last;
  assign rst_busy = (rst_left != 9'h000);
  assign rst_last = (rst_left == 9'h001);

  // Write-enable loads only when its own inhibit is written 0
  wire logic we_upd;
  assign we_upd = wr_done & hit_ctrl & ~wr_ctrl.we_inh & ~rst_busy;

  // Run loads only with inhibit 0 and write-enable already set beforehand,
  // so one write cannot both unlock and start
  wire logic run_upd;
  assign run_upd = wr_done & hit_ctrl & ~wr_ctrl.run_inh
                   & ctrl_write_enable_bit & ~rst_busy;

  // Counter write and overflow
  wire logic cnt_wr;
  wire logic ovf;
  assign cnt_wr = wr_done & hit_count & ~rst_busy;
  assign ovf = tick & wdog_run_bit & ~rst_busy
               & (wdog_counter == `WDT_CNT_MAX);

  // Next counter: overflow beats write, write beats a tick
  logic [7:0] next_counter;
  always_comb
  begin
    next_counter = wdog_counter;
    if (ovf)
      next_counter = `WDT_CNT_RESET;
    else if (cnt_wr)
      next_counter = pwdata_i[7:0];
    else if (tick && wdog_run_bit)
      next_counter = wdog_counter + 8'h01;
  end

  // Input clock prescaler, held in reset while stopped
  wdt_clk_div u_div (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .run_i(wdog_run_bit),
    .sel_i(clk_sel),
    .tick_o(tick)
  );

  // Counter register
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      wdog_counter <= `WDT_CNT_RESET;
    else
      wdog_counter <= next_counter;
  end

  // Control bits; overflow drops them so the watchdog stays stopped
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i || ovf)
    begin
      ctrl_write_enable_bit <= 1'b0;
      wdog_run_bit <= 1'b0;
      clk_sel <= wdt_pkg::wdt_div_t'(`WDT_CLKSEL_RESET);
    end
    else
    begin
      if (we_upd)
        ctrl_write_enable_bit <= wr_ctrl.we;
      if (run_upd)
        wdog_run_bit <= wr_ctrl.run;
      if (wr_done && hit_clksel && !rst_busy)
        clk_sel <= wdt_pkg::wdt_div_t'(pwdata_i[1:0]);
    end
  end

  // Internal reset length counter; output falls as the count hits zero
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      rst_left <= 9'h000;
      wdt_reset_o <= 1'b0;
    end
    else if (ovf)
    begin
      rst_left <= `WDT_RST_CYCLES;
      wdt_reset_o <= 1'b1;
    end
    else if (rst_busy)
    begin
      rst_left <= rst_left - 9'h001;
      wdt_reset_o <= ~rst_last;
    end
  end

  // Sticky events; clear only what the read returned so a set in the
  // same cycle as the read, or after data was latched, is never lost
  wdt_pkg::wdt_evt_t evt;
  wdt_pkg::wdt_evt_t rd_clr;
  wdt_pkg::wdt_evt_t next_status;
  assign evt.ovf = ovf;
  assign evt.rst_end = rst_last;
  assign rd_clr = (rd_done && hit_status) ?
                  wdt_pkg::wdt_evt_t'(prdata_o[1:0]) : 2'h0;
  assign next_status = (status & ~rd_clr) | evt;

  // Status, mask and interrupt
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      status <= `WDT_STATUS_RESET;
      mask <= `WDT_MASK_RESET;
      irq_o <= 1'b0;
    end
    else
    begin
      status <= next_status;
      if (wr_done && hit_mask)
        mask <= wdt_pkg::wdt_evt_t'(pwdata_i[1:0]);
      irq_o <= |(next_status & ((wr_done && hit_mask) ?
               wdt_pkg::wdt_evt_t'(pwdata_i[1:0]) : mask));
    end
  end

  // Read mux; inhibit bits are write-only and read as one
  wire logic [31:0] rd_data;
  assign rd_data =
    hit_ctrl ? {28'h0000000, 1'b1, wdog_run_bit, 1'b1,
                ctrl_write_enable_bit} :
    hit_count ? {24'h000000, wdog_counter} :
    hit_clksel ? {30'h00000000, clk_sel} :
    hit_status ? {30'h00000000, status} :
    hit_mask ? {30'h00000000, mask} :
    32'h00000000;

  // APB answer: one wait state, data and error latched with pready
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end
    else
    begin
      pready_o <= access_cyc;
      pslverr_o <= access_cyc & ~hit_any;
      if (access_cyc && !pwrite_i)
        prdata_o <= rd_data;
    end
  end

  // Checking helpers: reset pulse length and ticks since last preload
  logic [8:0] hi_len;
  logic [8:0] tk_seen;
  logic [7:0] preload;
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      hi_len <= 9'h000;
      tk_seen <= 9'h000;
      preload <= `WDT_CNT_RESET;
    end
    else
    begin
      hi_len <= wdt_reset_o ? hi_len + 9'h001 : 9'h000;
      if (ovf || cnt_wr)
      begin
        tk_seen <= 9'h000;
        preload <= next_counter;
      end
      else if (tick && wdog_run_bit && !rst_busy)
        tk_seen <= tk_seen + 9'h001;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  AST_CNT_STEP: assert property (
    (tick && wdog_run_bit && !ovf && !cnt_wr && !rst_busy)
    |=> wdog_counter == $past(wdog_counter) + 8'h01)
    else $error("counter did not step on an input clock");

  AST_START: assert property (
    $rose(wdog_run_bit) |-> $past(wr_done && hit_ctrl
      && ctrl_write_enable_bit && !pwdata_i[3] && pwdata_i[2]))
    else $error("watchdog started without an unlocked run write");

  AST_OVF: assert property (
    (tick && wdog_run_bit && !rst_busy && wdog_counter == 8'hFF)
    |=> wdt_reset_o && status.ovf)
    else $error("overflow did not raise the reset request");

  // Helper has counted every edge of the pulse when the fall is first seen
  AST_RST_LEN: assert property (
    $fell(wdt_reset_o) |-> hi_len == `WDT_RST_CYCLES)
    else $error("internal reset not 256 cycles long");

  AST_WRITE: assert property (
    (cnt_wr && !ovf) |=> wdog_counter == $past(pwdata_i[7:0]))
    else $error("counter write not taken");

  AST_INTERVAL: assert property (
    ovf |-> ({1'b0, preload} + tk_seen) == 9'h0FF)
    else $error("overflow interval does not match preload");

  AST_STOPPED: assert property (
    wdt_reset_o |-> !wdog_run_bit && !ctrl_write_enable_bit
      && wdog_counter == `WDT_CNT_RESET && clk_sel == wdt_pkg::WDT_DIV_1)
    else $error("watchdog state not cleared during reset");

  AST_IRQ: assert property (
    irq_o == |(status & mask))
    else $error("interrupt level disagrees with status and mask");

endmodule : wdt_top

// file: include/wdt_map.svh
// Register offsets, field positions, reset values and counts of the watchdog
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// Register byte offsets on the APB bus
`define WDT_OFF_CTRL 8'h00
`define WDT_OFF_COUNT 8'h04
`define WDT_OFF_CLKSEL 8'h08
`define WDT_OFF_STATUS 8'h0C
`define WDT_OFF_MASK 8'h10

// Control register field positions
`define WDT_CTRL_WE_BIT 0
`define WDT_CTRL_WE_INH_BIT 1
`define WDT_CTRL_RUN_BIT 2
`define WDT_CTRL_RUN_INH_BIT 3

// Status and mask register field positions
`define WDT_ST_OVF_BIT 0
`define WDT_ST_RST_END_BIT 1

// Reset values and the counter maximum
`define WDT_CNT_RESET 8'h00
`define WDT_CNT_MAX 8'hFF
`define WDT_CLKSEL_RESET 2'h0
`define WDT_STATUS_RESET 2'h0
`define WDT_MASK_RESET 2'h0

// Internal reset length in oscillator (system) clock cycles
`define WDT_RST_CYCLES 9'h100

// Input clock divide ratios selected by the clock select register
`define WDT_DIV_SEL0 10'h001
`define WDT_DIV_SEL1 10'h008
`define WDT_DIV_SEL2 10'h040
`define WDT_DIV_SEL3 10'h200

`endif

// file: include/wdt_pkg.sv
// Types shared by the watchdog design files
package wdt_pkg;

  // Fields of a control register write, bit 3 down to bit 0
  typedef struct packed {
    logic run_inh;
    logic run;
    logic we_inh;
    logic we;
  } wdt_ctrl_t;

  // Sticky events, bit 1 down to bit 0
  typedef struct packed {
    logic rst_end;
    logic ovf;
  } wdt_evt_t;

  // Input clock rate selections
  typedef enum logic [1:0] {
    WDT_DIV_1 = 2'b00,
    WDT_DIV_8 = 2'b01,
    WDT_DIV_64 = 2'b10,
    WDT_DIV_512 = 2'b11
  } wdt_div_t;

endpackage : wdt_pkg

// file: test/test_wdt_top.sv
// Self-checking bench for the watchdog reset timer
`include "wdt_map.svh"

module test_wdt_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic wdt_rst;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int n;

  wdt_top u_wdt_top (
    .clk_sys_i(clk),
    .reset_i(rst),
    .psel_i(psel),
    .penable_i(penable),
    .pwrite_i(pwrite),
    .paddr_i(paddr),
    .pwdata_i(pwdata),
    .prdata_o(prdata),
    .pready_o(pready),
    .pslverr_o(pslverr),
    .irq_o(irq),
    .wdt_reset_o(wdt_rst)
  );

  // 25 MHz system clock
  initial
  begin
    forever #20 clk = ~clk;
  end

  // Hang guard: the whole run needs only a few thousand cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end

  task finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task chk(input string what, input logic [31:0] got,
           input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; the slave's wait states are not assumed
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    w = 0;
    @(posedge clk);
    while (pready !== 1'b1 && w < 50)
    begin
      @(posedge clk);
      w++;
    end
    rd = prdata;
    err = pslverr;
    chk("pready", {31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Cycles until the internal reset is seen high
  task wait_rise(output int c);
    c = 0;
    @(posedge clk);
    while (wdt_rst !== 1'b1 && c < 2000)
    begin
      @(posedge clk);
      c++;
    end
  endtask : wait_rise

  // Number of edges at which the internal reset is high
  task pulse_len(output int c);
    c = 1;
    @(posedge clk);
    while (wdt_rst === 1'b1 && c < 400)
    begin
      @(posedge clk);
      c++;
    end
  endtask : pulse_len

  task t_reset_vals;
    logic [7:0] offs [4];
    offs = '{`WDT_OFF_COUNT, `WDT_OFF_CLKSEL, `WDT_OFF_STATUS,
             `WDT_OFF_MASK};
    apb(1'b0, `WDT_OFF_CTRL, 32'h0);
    chk("ctrl_reset", rd, 32'h0000000A);
    foreach (offs[i])
    begin
      apb(1'b0, offs[i], 32'h0);
      chk("reg_reset", rd, 32'h00000000);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped_rd_err", {31'h0, err}, 32'h1);
    chk("unmapped_rd_data", rd, 32'h0);
    apb(1'b1, 8'h40, 32'hFFFFFFFF);
    chk("unmapped_wr_err", {31'h0, err}, 32'h1);
  endtask : t_reset_vals

  // A single write can never both unlock and start the count
  task t_start_guard;
    apb(1'b1, `WDT_OFF_CTRL, 32'h5);
    repeat (8) @(posedge clk);
    apb(1'b0, `WDT_OFF_COUNT, 32'h0);
    chk("count_one_write", rd, 32'h0);
    apb(1'b1, `WDT_OFF_CTRL, 32'hD);
    repeat (8) @(posedge clk);
    apb(1'b0, `WDT_OFF_COUNT, 32'h0);
    chk("count_run_inhibit", rd, 32'h0);
    apb(1'b0, `WDT_OFF_CTRL, 32'h0);
    chk("ctrl_we_only", rd, 32'h0000000B);
    apb(1'b1, `WDT_OFF_CTRL, 32'h5);
    apb(1'b0, `WDT_OFF_CTRL, 32'h0);
    chk("ctrl_running", rd, 32'h0000000F);
    repeat (5) @(posedge clk);
    apb(1'b0, `WDT_OFF_COUNT, 32'h0);
    chk("count_moves", {31'h0, rd != 32'h0}, 32'h1);
    apb(1'b1, `WDT_OFF_CTRL, 32'h1);
  endtask : t_start_guard

  // Run for a while at one rate from a preload, stop, read the count back
  task step_run(input logic [1:0] sel, input logic [7:0] pre,
                input int cyc);
    apb(1'b1, `WDT_OFF_CLKSEL, {30'h0, sel});
    apb(1'b1, `WDT_OFF_COUNT, {24'h0, pre});
    apb(1'b1, `WDT_OFF_CTRL, 32'h5);
    repeat (cyc) @(posedge clk);
    apb(1'b1, `WDT_OFF_CTRL, 32'h1);
    apb(1'b0, `WDT_OFF_COUNT, 32'h0);
  endtask : step_run

  // Rates 512, 8 and 64: the stop lands cyc+4 cycles after start, away from a tick
  task t_prescale;
    step_run(2'h3, 8'h10, 600);
    chk("count_div512", rd, 32'h11);
    step_run(2'h1, 8'h20, 58);
    chk("count_div8", rd, 32'h27);
    step_run(2'h2, 8'h30, 100);
    chk("count_div64", rd, 32'h31);
  endtask : t_prescale

  // Preload FF: one input clock to overflow, then a 256-cycle reset
  task t_overflow;
    apb(1'b1, `WDT_OFF_MASK, 32'h3);
    apb(1'b1, `WDT_OFF_CLKSEL, 32'h1);
    apb(1'b1, `WDT_OFF_COUNT, 32'hFF);
    apb(1'b1, `WDT_OFF_CTRL, 32'h5);
    wait_rise(n);
    chk("ovf_one_tick", n, 32'h8);
    pulse_len(n);
    chk("reset_len", n, 32'h100);
    repeat (2) @(posedge clk);
    chk("irq_set", {31'h0, irq}, 32'h1);
    apb(1'b1, `WDT_OFF_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    apb(1'b1, `WDT_OFF_MASK, 32'h3);
    apb(1'b0, `WDT_OFF_STATUS, 32'h0);
    chk("status", rd, 32'h3);
    repeat (2) @(posedge clk);
    chk("irq_cleared", {31'h0, irq}, 32'h0);
    apb(1'b0, `WDT_OFF_CTRL, 32'h0);
    chk("ctrl_after_ovf", rd, 32'h0000000A);
    apb(1'b0, `WDT_OFF_CLKSEL, 32'h0);
    chk("clksel_after_ovf", rd, 32'h0);
  endtask : t_overflow

  // Preload 00: the longest period; writes in the pulse are ignored
  task t_full_period;
    apb(1'b1, `WDT_OFF_COUNT, 32'h0);
    apb(1'b1, `WDT_OFF_CTRL, 32'h1);
    apb(1'b1, `WDT_OFF_CTRL, 32'h5);
    wait_rise(n);
    chk("ovf_256_ticks", n, 32'h100);
    apb(1'b1, `WDT_OFF_COUNT, 32'h55);
    apb(1'b1, `WDT_OFF_CTRL, 32'h1);
    pulse_len(n);
    apb(1'b0, `WDT_OFF_COUNT, 32'h0);
    chk("count_after_ovf", rd, 32'h0);
    apb(1'b0, `WDT_OFF_CTRL, 32'h0);
    chk("ctrl_stopped", rd, 32'h0000000A);
    apb(1'b0, `WDT_OFF_STATUS, 32'h0);
    chk("status_again", rd, 32'h3);
  endtask : t_full_period

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset_vals();
    t_start_guard();
    t_prescale();
    t_overflow();
    t_full_period();
    finish_test();
  end
endmodule : test_wdt_top
